// *** scrp_device.sv ***
/*
  configuration port end: receives address and data frames over the
  serial link, keeps a bank of configuration registers and returns
  read data serially.
  assumes the link pins are asynchronous to clk_sys and that the shift
  clock is slow enough to be sampled by clk_sys.
*/
`default_nettype none

module scrp_device
  import scrp_pkg::*;
#(
  parameter int NREG = NREG_DEFAULT
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  ce,
  scrp_if.dev                        link,
  output logic     [NREG*32-1:0]     cfgRegs,
  output logic                       wrPulse,
  output logic     [ADDR_BITS-1:0]   wrAddr,
  output logic                       rdPulse,
  input  wire logic                  softResetReq
);

  localparam int IDXW = (NREG > 1) ? $clog2(NREG) : 1;
  localparam int NPIN = 5;
  // pin order: shift clock, load, direction, data in, config reset
  localparam logic [NPIN-1:0] PIN_RESET = {4'h0, CFGRST_IDLE};

  typedef enum logic {
    S_RECV = 1'b0,
    S_SEND = 1'b1
  } scrp_dstate_t;

  logic [NPIN-1:0]       pinRaw;
  logic [NPIN-1:0]       meta_q;
  logic [NPIN-1:0]       sync_q;
  logic                  sclkPrev_q;
  logic                  loadPrev_q;
  logic                  sclkS;
  logic                  loadS;
  logic                  wnrS;
  logic                  sdiS;
  logic                  cfgRstNS;
  logic                  sclkRise;
  logic                  sclkFall;
  logic                  loadRise;
  scrp_dstate_t          state_q;
  logic [FRAME_BITS-1:0] rxSr_q;
  logic [DATA_BITS-1:0]  txSr_q;
  logic [4:0]            sendCnt_q;
  logic [31:0]           reg_q [NREG];
  logic [ADDR_BITS-1:0]  wrAddrIn;
  logic [DATA_BITS-1:0]  wrDataIn;
  logic [ADDR_BITS-1:0]  rdAddrIn;
  logic                  wrMapped;
  logic                  rdMapped;
  logic [IDXW-1:0]       wrIdx;
  logic [IDXW-1:0]       rdIdx;
  logic                  wrHit;
  logic                  rdHit;
  logic [31:0]           rdWord;
  logic                  softRst_q;
  logic                  wrPulse_q;
  logic [ADDR_BITS-1:0]  wrAddr_q;
  logic                  rdPulse_q;

  assign pinRaw = {link.serialShiftClock, link.transferLoadStrobe,
                   link.writeNotReadSelect, link.serialDataToDevice,
                   link.defaultConfigResetN};

  // two-stage synchroniser per link pin
  for (genvar p = 0; p < NPIN; p++) begin : g_sync
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        meta_q[p] <= PIN_RESET[p];
        sync_q[p] <= PIN_RESET[p];
      end else if (ce) begin
        meta_q[p] <= pinRaw[p];
        sync_q[p] <= meta_q[p];
      end
    end
  end

  assign sclkS    = sync_q[4];
  assign loadS    = sync_q[3];
  assign wnrS     = sync_q[2];
  assign sdiS     = sync_q[1];
  assign cfgRstNS = sync_q[0];

  // edge detection on the synchronised shift clock and load strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sclkPrev_q <= 1'b0;
      loadPrev_q <= 1'b0;
    end else if (ce) begin
      sclkPrev_q <= sclkS;
      loadPrev_q <= loadS;
    end
  end

  // shift clock is sampled, never used as a clock
  assign sclkRise = sclkS & ~sclkPrev_q;
  assign sclkFall = ~sclkS & sclkPrev_q;
  assign loadRise = loadS & ~loadPrev_q;

  // frame decode: address ahead of data, both MSB first
  assign wrAddrIn = rxSr_q[FRAME_BITS-1:DATA_BITS];
  assign wrDataIn = rxSr_q[DATA_BITS-1:0];
  assign rdAddrIn = rxSr_q[ADDR_BITS-1:0];
  assign wrMapped = ({20'h0_0000, wrAddrIn} < 32'(NREG));
  assign rdMapped = ({20'h0_0000, rdAddrIn} < 32'(NREG));
  assign wrIdx    = wrAddrIn[IDXW-1:0];
  assign rdIdx    = rdAddrIn[IDXW-1:0];
  assign wrHit    = loadRise & wnrS;
  assign rdHit    = loadRise & ~wnrS;
  assign rdWord   = rdMapped ? reg_q[rdIdx] : 32'h0000_0000;

  // serial input shift, cleared on the load edge and frozen while the load strobe stays high
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxSr_q <= '0;
    end else if (ce) begin
      if (loadRise) begin
        rxSr_q <= '0;
      end else if (sclkRise && !loadS) begin
        rxSr_q <= {rxSr_q[FRAME_BITS-2:0], sdiS};
      end
    end
  end

  // read sequencer: bit 0 on the load edge, then one bit per falling edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q   <= S_RECV;
      txSr_q    <= '0;
      sendCnt_q <= 5'h00;
    end else if (ce) begin
      if (!cfgRstNS) begin
        state_q   <= S_RECV;
        txSr_q    <= '0;
        sendCnt_q <= 5'h00;
      end else if (rdHit) begin
        state_q   <= S_SEND;
        txSr_q    <= rdWord;
        sendCnt_q <= 5'h00;
      end else if (wrHit) begin
        state_q   <= S_RECV;
        txSr_q    <= '0;
      end else begin
        unique case (state_q)
          S_RECV: begin
            txSr_q <= '0;
          end
          S_SEND: begin
            // the fall that ends the load strobe keeps bit 0 on the line
            if (sclkFall && !loadS && !loadPrev_q) begin
              if (sendCnt_q == 5'h1F) begin
                state_q <= S_RECV;
                txSr_q  <= '0;
              end else begin
                txSr_q    <= {1'b0, txSr_q[DATA_BITS-1:1]};
                sendCnt_q <= sendCnt_q + 5'h01;
              end
            end
          end
        endcase
      end
    end
  end

  // register bank, defaults held while the config reset is low
  for (genvar r = 0; r < NREG; r++) begin : g_reg
    always_ff @(posedge clk_sys) begin
      if (rst || !cfgRstNS) begin
        reg_q[r] <= REG_RESET;
      end else if (ce && wrHit && wrMapped && (wrIdx == IDXW'(r))) begin
        reg_q[r] <= wrDataIn;
      end
    end
    assign cfgRegs[r*32 +: 32] = reg_q[r];
  end

  // user-side strobes and the soft reset request pin
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrPulse_q <= 1'b0;
      wrAddr_q  <= '0;
      rdPulse_q <= 1'b0;
      softRst_q <= 1'b0;
    end else if (ce) begin
      wrPulse_q <= wrHit & cfgRstNS;
      rdPulse_q <= rdHit & cfgRstNS;
      softRst_q <= softResetReq;
      if (wrHit) begin
        wrAddr_q <= wrAddrIn;
      end
    end
  end

  assign wrPulse                   = wrPulse_q;
  assign wrAddr                    = wrAddr_q;
  assign rdPulse                   = rdPulse_q;
  // low while idle, bit stream while sending
  assign link.serialDataFromDevice = txSr_q[0];
  assign link.softResetRequestN    = ~softRst_q;

endmodule

`default_nettype wire

// *** scrp_host.sv ***
/*
  configuration controller end: makes the shift clock by dividing
  clk_sys, shifts out address and data, pulses the load strobe and
  collects read data.
  assumes one transaction at a time requested by the user side.
*/
`default_nettype none

module scrp_host
  import scrp_pkg::*;
#(
  parameter int HALF_CYCLES = HALF_CYC
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  input  wire logic                 ce,
  scrp_if.host                      link,
  input  wire logic                 start,
  input  wire logic                 startWrite,
  input  wire logic [ADDR_BITS-1:0] startAddr,
  input  wire logic [DATA_BITS-1:0] startData,
  input  wire logic                 cfgResetReq,
  output logic                      busy,
  output logic                      done,
  output logic     [DATA_BITS-1:0]  readData,
  output logic                      softResetSeen
);

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_SHIFT = 3'b001,
    H_PREP  = 3'b011,
    H_LOAD  = 3'b010,
    H_READ  = 3'b110
  } scrp_hstate_t;

  scrp_hstate_t          state_q;
  logic [15:0]           divCnt_q;
  logic                  sclk_q;
  logic                  tick;
  logic                  fallEv;
  logic                  riseEv;
  logic [1:0]            meta_q;
  logic [1:0]            sync_q;
  logic [FRAME_BITS-1:0] txSr_q;
  logic [5:0]            bitCnt_q;
  logic [5:0]            lastBit;
  logic                  isWrite_q;
  logic                  mosi_q;
  logic                  load_q;
  logic                  wnr_q;
  logic [DATA_BITS-1:0]  rxSr_q;
  logic                  done_q;
  logic                  cfgRstN_q;

  // free-running divider makes the 0.5 MHz shift clock
  assign tick   = (divCnt_q == 16'(HALF_CYCLES - 1));
  assign fallEv = tick & sclk_q;
  assign riseEv = tick & ~sclk_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      divCnt_q <= 16'h0000;
      sclk_q   <= 1'b0;
    end else if (ce) begin
      divCnt_q <= tick ? 16'h0000 : divCnt_q + 16'h0001;
      if (tick) begin
        sclk_q <= ~sclk_q;
      end
    end
  end

  // two-stage synchroniser: {soft reset request, read data}
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= {SOFTRST_IDLE, SDO_IDLE};
      sync_q <= {SOFTRST_IDLE, SDO_IDLE};
    end else if (ce) begin
      meta_q <= {link.softResetRequestN, link.serialDataFromDevice};
      sync_q <= meta_q;
    end
  end

  // 44 bits for a write, 12 for a read
  assign lastBit = isWrite_q ? 6'(FRAME_BITS - 1) : 6'(ADDR_BITS - 1);

  // transaction sequencer: data out and load strobe change on shift clock falls, direction on start
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q   <= H_IDLE;
      txSr_q    <= '0;
      bitCnt_q  <= 6'h00;
      isWrite_q <= 1'b0;
      mosi_q    <= 1'b0;
      load_q    <= 1'b0;
      wnr_q     <= 1'b0;
      rxSr_q    <= '0;
      done_q    <= 1'b0;
    end else if (ce) begin
      done_q <= 1'b0;
      unique case (state_q)
        H_IDLE: begin
          if (start) begin
            txSr_q    <= {startAddr, startData};
            isWrite_q <= startWrite;
            wnr_q     <= startWrite;
            bitCnt_q  <= 6'h00;
            state_q   <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (fallEv) begin
            mosi_q   <= txSr_q[FRAME_BITS-1];
            txSr_q   <= {txSr_q[FRAME_BITS-2:0], 1'b0};
            bitCnt_q <= bitCnt_q + 6'h01;
            if (bitCnt_q == lastBit) begin
              state_q <= H_PREP;
            end
          end
        end
        H_PREP: begin
          if (fallEv) begin
            mosi_q  <= 1'b0;
            load_q  <= 1'b1;
            state_q <= H_LOAD;
          end
        end
        H_LOAD: begin
          if (fallEv) begin
            load_q   <= 1'b0;
            bitCnt_q <= 6'h00;
            if (isWrite_q) begin
              done_q  <= 1'b1;
              state_q <= H_IDLE;
            end else begin
              rxSr_q  <= '0;
              state_q <= H_READ;
            end
          end
        end
        H_READ: begin
          if (riseEv) begin
            rxSr_q   <= {sync_q[0], rxSr_q[DATA_BITS-1:1]};
            bitCnt_q <= bitCnt_q + 6'h01;
            if (bitCnt_q == 6'(DATA_BITS - 1)) begin
              done_q  <= 1'b1;
              state_q <= H_IDLE;
            end
          end
        end
        default: begin
          state_q <= H_IDLE;
        end
      endcase
    end
  end

  // default-configuration reset pin, active low
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfgRstN_q <= CFGRST_IDLE;
    end else if (ce) begin
      cfgRstN_q <= ~cfgResetReq;
    end
  end

  assign busy                    = (state_q != H_IDLE);
  assign done                    = done_q;
  assign readData                = rxSr_q;
  assign softResetSeen           = ~sync_q[1];
  assign link.serialShiftClock   = sclk_q;
  assign link.transferLoadStrobe = load_q;
  assign link.writeNotReadSelect = wnr_q;
  assign link.serialDataToDevice = mosi_q;
  assign link.defaultConfigResetN = cfgRstN_q;

endmodule

`default_nettype wire

// *** scrp_if.sv ***
/*
  serial configuration link between the configuration controller
  (host) and the configuration port in programmable logic (dev).
  all wires are point to point; no two-way pins.
*/
`default_nettype none

interface scrp_if;
  logic serialShiftClock;
  logic transferLoadStrobe;
  logic writeNotReadSelect;
  logic serialDataToDevice;
  logic serialDataFromDevice;
  logic defaultConfigResetN;
  logic softResetRequestN;

  // configuration port end
  modport dev (
    input  serialShiftClock,
    input  transferLoadStrobe,
    input  writeNotReadSelect,
    input  serialDataToDevice,
    input  defaultConfigResetN,
    output serialDataFromDevice,
    output softResetRequestN
  );

  // configuration controller end
  modport host (
    output serialShiftClock,
    output transferLoadStrobe,
    output writeNotReadSelect,
    output serialDataToDevice,
    output defaultConfigResetN,
    input  serialDataFromDevice,
    input  softResetRequestN
  );
endinterface

`default_nettype wire

// *** scrp_link_checker.sv ***
/*
  concurrent checks on the serial configuration link wires.
  assumes the host divider half period HALF_CYCLES is 8 clk_sys cycles.
*/
`default_nettype none

module scrp_link_checker #(
  parameter int HALF_CYCLES = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic serialShiftClock,
  input wire logic transferLoadStrobe,
  input wire logic writeNotReadSelect,
  input wire logic serialDataToDevice,
  input wire logic serialDataFromDevice,
  input wire logic defaultConfigResetN,
  input wire logic softResetRequestN
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LOAD_LEN = 2 * HALF_CYCLES;
  logic [7:0] loadCntQ;
  logic [7:0] loadCntD;

  // cycles the load strobe has stood high
  assign loadCntD = transferLoadStrobe ? loadCntQ + 8'h01 : 8'h00;
  always_ff @(posedge clk_sys) begin
    if (rst)
      loadCntQ <= 8'h00;
    else
      loadCntQ <= loadCntD;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // rest of each shift clock phase
  sequence highRest;
    serialShiftClock [*7] ##1 !serialShiftClock;
  endsequence
  sequence lowRest;
    !serialShiftClock [*7] ##1 serialShiftClock;
  endsequence

  sclk_high_phase_a: assert property ($rose(serialShiftClock) |=> highRest)
    else $error("shift clock high phase has wrong length");
  sclk_low_phase_a: assert property ($fell(serialShiftClock) |=> lowRest)
    else $error("shift clock low phase has wrong length");
  mosi_hold_a: assert property ((serialShiftClock && $past(serialShiftClock)) |->
    $stable(serialDataToDevice)) else $error("data to device moved while clock high");
  load_width_a: assert property ($fell(transferLoadStrobe) |->
    loadCntQ == 8'(LOAD_LEN)) else $error("load strobe not one shift period");
  dir_stable_a: assert property (transferLoadStrobe |-> $stable(writeNotReadSelect))
    else $error("direction moved during load");
  reset_idle_a: assert property ($past(rst) |-> (!serialDataFromDevice &&
    softResetRequestN && defaultConfigResetN && !transferLoadStrobe))
    else $error("link not idle after reset");
  write_sdo_low_a: assert property ((transferLoadStrobe && writeNotReadSelect) |->
    !serialDataFromDevice) else $error("read data driven during write load");
  cfgrst_sdo_low_a: assert property ((!defaultConfigResetN &&
    !$past(defaultConfigResetN, 4)) |-> !serialDataFromDevice)
    else $error("read data driven during config reset");
  sdo_hold_a: assert property (serialShiftClock |-> $stable(serialDataFromDevice))
    else $error("read data moved while clock high");
endmodule

`default_nettype wire

// *** scrp_pkg.sv ***
/*
  constants shared by both ends of the serial configuration port:
  frame field widths, link timing and register reset values.
  assumes a 250 MHz system clock on both ends.
*/
`default_nettype none

package scrp_pkg;

  // frame layout
  localparam int ADDR_BITS  = 12;
  localparam int DATA_BITS  = 32;
  localparam int FRAME_BITS = ADDR_BITS + DATA_BITS;

  // link timing: shift clock period in ns, system clock period in ns
  localparam int LINK_PERIOD_NS = 2000;
  localparam int SYS_PERIOD_NS  = 4;
  localparam int HALF_CYC       = (LINK_PERIOD_NS / 2) / SYS_PERIOD_NS;

  // register bank
  localparam int          NREG_DEFAULT = 4;
  localparam logic [31:0] REG_RESET    = 32'h0000_0000;

  // pin levels while idle or held in reset
  localparam logic        SDO_IDLE     = 1'b0;
  localparam logic        SOFTRST_IDLE = 1'b1;
  localparam logic        CFGRST_IDLE  = 1'b1;

endpackage

`default_nettype wire

// *** tb_top.sv ***
/*
  self-checking bench: host and device ends joined by one link.
  assumes host divider of 8 cycles per half period, four registers.
*/
`default_nettype none

module tb_top
  import scrp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF  = 8;
  localparam int LIMIT = 60000;
  logic                 clk_sys       = 1'b0;
  logic                 rst           = 1'b1;
  logic                 start         = 1'b0;
  logic                 startWrite    = 1'b0;
  logic [ADDR_BITS-1:0] startAddr     = 12'h000;
  logic [DATA_BITS-1:0] startData     = 32'h0000_0000;
  logic                 cfgResetReq   = 1'b0;
  logic                 softResetReq  = 1'b0;
  logic                 devCe         = 1'b1;
  logic                 busy;
  logic                 done;
  logic                 softResetSeen;
  logic                 wrPulse;
  logic                 rdPulse;
  logic [DATA_BITS-1:0] readData;
  logic [ADDR_BITS-1:0] wrAddr;
  logic [4*32-1:0]      cfgRegs;
  logic [31:0]          expRegs [4];
  integer               seed          = 89;
  int                   fails         = 0;
  int                   n_compared    = 0;
  int                   cycles        = 0;
  int                   nWr           = 0;
  int                   nRd           = 0;

  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  scrp_if link_bus ();

  scrp_host #(.HALF_CYCLES(HALF)) scrp_host_inst (
    .clk_sys(clk_sys), .rst(rst), .ce(1'b1), .link(link_bus.host), .start(start),
    .startWrite(startWrite), .startAddr(startAddr), .startData(startData),
    .cfgResetReq(cfgResetReq), .busy(busy), .done(done), .readData(readData),
    .softResetSeen(softResetSeen)
  );

  scrp_device #(.NREG(4)) scrp_device_inst (
    .clk_sys(clk_sys), .rst(rst), .ce(devCe), .link(link_bus.dev), .cfgRegs(cfgRegs),
    .wrPulse(wrPulse), .wrAddr(wrAddr), .rdPulse(rdPulse), .softResetReq(softResetReq)
  );

  scrp_link_checker #(.HALF_CYCLES(HALF)) scrp_link_checker_inst (
    .clk_sys(clk_sys), .rst(rst),
    .serialShiftClock(link_bus.serialShiftClock),
    .transferLoadStrobe(link_bus.transferLoadStrobe),
    .writeNotReadSelect(link_bus.writeNotReadSelect),
    .serialDataToDevice(link_bus.serialDataToDevice),
    .serialDataFromDevice(link_bus.serialDataFromDevice),
    .defaultConfigResetN(link_bus.defaultConfigResetN),
    .softResetRequestN(link_bus.softResetRequestN)
  );

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // expected read word: unmapped places read as zero
  function automatic logic [31:0] expRead(input logic [11:0] a);
    return (a < 12'h004) ? expRegs[a[1:0]] : 32'h0000_0000;
  endfunction

  task automatic checkBank();
    for (int r = 0; r < 4; r++)
      check(cfgRegs[r*32 +: 32], expRegs[r]);
  endtask

  // one host transaction, waits for done under a bound
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    while (busy !== 1'b0)
      @(negedge clk_sys);
    @(posedge clk_sys);
    start <= 1'b1;
    startWrite <= wr;
    startAddr <= a;
    startData <= d;
    @(posedge clk_sys);
    start <= 1'b0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (done !== 1'b1 && n < 2000);
    check(32'(n < 2000), 32'h0000_0001);
  endtask

  // pulse counts and cycle ceiling
  always @(negedge clk_sys) begin
    cycles++;
    if (wrPulse === 1'b1)
      nWr++;
    if (rdPulse === 1'b1)
      nRd++;
    if (cycles == LIMIT) begin
      fails++;
      summarize();
    end
  end

  // main sequence
  initial begin
    logic [11:0] a;
    logic [31:0] d;
    for (int r = 0; r < 4; r++)
      expRegs[r] = REG_RESET;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check(32'(link_bus.serialDataFromDevice), 32'(SDO_IDLE));
    check(32'(link_bus.softResetRequestN), 32'(SOFTRST_IDLE));
    checkBank();
    $display("test idle levels done");
    for (int i = 0; i < 10; i++) begin
      a = (i < 2) ? 12'(i * 3) : 12'($random(seed) & 3);
      d = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h8000_0001 : 32'($random(seed));
      xfer(1'b1, a, d);
      expRegs[a[1:0]] = d;
      checkBank();
      check(32'(wrAddr), 32'(a));
    end
    check(32'(nWr), 32'h0000_000A);
    $display("test writes done");
    for (int r = 0; r < 4; r++) begin
      xfer(1'b0, 12'(r), 32'($random(seed)));
      check(readData, expRead(12'(r)));
    end
    check(32'(nRd), 32'h0000_0004);
    $display("test reads done");
    xfer(1'b1, 12'hFFF, 32'($random(seed)));
    check(32'(wrAddr), 32'h0000_0FFF);
    checkBank();
    xfer(1'b0, 12'h004, 32'h0000_0000);
    check(readData, expRead(12'h004));
    $display("test unmapped done");
    // a frozen device must ignore a whole write
    @(posedge clk_sys);
    devCe <= 1'b0;
    xfer(1'b1, 12'h002, 32'hDEAD_0002);
    checkBank();
    @(posedge clk_sys);
    devCe <= 1'b1;
    $display("test clock enable done");
    @(posedge clk_sys);
    cfgResetReq <= 1'b1;
    repeat (8) @(negedge clk_sys);
    check(32'(link_bus.defaultConfigResetN), 32'h0000_0000);
    for (int r = 0; r < 4; r++)
      expRegs[r] = REG_RESET;
    checkBank();
    xfer(1'b1, 12'h001, 32'h5A5A_A5A5);
    checkBank();
    @(posedge clk_sys);
    cfgResetReq <= 1'b0;
    xfer(1'b0, 12'h001, 32'h0000_0000);
    check(readData, expRead(12'h001));
    xfer(1'b1, 12'h001, 32'h5A5A_A5A5);
    expRegs[1] = 32'h5A5A_A5A5;
    checkBank();
    $display("test config reset done");
    @(posedge clk_sys);
    softResetReq <= 1'b1;
    repeat (6) @(negedge clk_sys);
    check(32'(link_bus.softResetRequestN), 32'h0000_0000);
    check(32'(softResetSeen), 32'h0000_0001);
    @(posedge clk_sys);
    softResetReq <= 1'b0;
    repeat (6) @(negedge clk_sys);
    check(32'(softResetSeen), 32'h0000_0000);
    $display("test soft reset done");
    summarize();
  end
endmodule

`default_nettype wire
